// *** src/e1lm_pkg.sv ***
/*
 * Shared definitions for the E1 line maintenance control block:
 * register offsets, field positions, reset values, writable masks,
 * detection limits, timing constants and the carrier and state structs.
 * Assumes an 8-bit register port and a 10 MHz device clock.
 */
package e1lm_pkg;

    // ====
    // Register map
    localparam logic [7:0] OFS_RX_CODE      = 8'h28;
    localparam logic [7:0] OFS_RX_LEVEL     = 8'h29;
    localparam logic [7:0] OFS_SLICER       = 8'h2A;
    localparam logic [7:0] OFS_LOOPBACK     = 8'h2B;
    localparam logic [7:0] OFS_LOSS_CTRL    = 8'h2C;
    localparam logic [7:0] OFS_VIOL_EXZ     = 8'h31;
    localparam logic [7:0] OFS_TERM         = 8'h32;
    localparam logic [7:0] OFS_LINE_STATUS  = 8'h36;
    localparam logic [7:0] OFS_EXZ_CNT_LO   = 8'h40;
    localparam logic [7:0] OFS_EXZ_CNT_HI   = 8'h41;

    localparam logic [7:0] RST_RX_CODE      = 8'h00;
    localparam logic [7:0] RST_RX_LEVEL     = 8'h15;
    localparam logic [7:0] RST_SLICER       = 8'h18;
    localparam logic [7:0] RST_LOOPBACK     = 8'h00;
    localparam logic [7:0] RST_LOSS_CTRL    = 8'h00;
    localparam logic [7:0] RST_VIOL_EXZ     = 8'h00;
    localparam logic [7:0] RST_TERM         = 8'h07;

    localparam logic [7:0] MSK_RX_CODE      = 8'h01;
    localparam logic [7:0] MSK_RX_LEVEL     = 8'h5F;
    localparam logic [7:0] MSK_SLICER       = 8'h3F;
    localparam logic [7:0] MSK_LOOPBACK     = 8'h77;
    localparam logic [7:0] MSK_LOSS_CTRL    = 8'h1C;
    localparam logic [7:0] MSK_VIOL_EXZ     = 8'h5F;
    localparam logic [7:0] MSK_TERM         = 8'h3F;

    // ====
    // Field positions
    localparam int BIT_RX_CODE_AMI   = 0;
    localparam int BIT_LONG_HAUL     = 6;
    localparam int POS_LOSS_THR      = 0;
    localparam int POS_MARK_THR      = 4;
    localparam int POS_PEAK_PER      = 2;
    localparam int POS_MON_GAIN      = 0;
    localparam int BIT_LB_DIGITAL1   = 6;
    localparam int BIT_LB_SYS_LOCAL  = 5;
    localparam int BIT_LB_SYS_REMOTE = 4;
    localparam int BIT_LB_REMOTE     = 2;
    localparam int BIT_LB_ANALOG     = 1;
    localparam int BIT_LB_DIGITAL2   = 0;
    localparam int BIT_LOSS_CRIT     = 4;
    localparam int BIT_RX_ALL_ONES   = 3;
    localparam int BIT_TX_ALL_ONES   = 2;
    localparam int BIT_VIOL_INJECT   = 6;
    localparam int BIT_EXZ_CRIT      = 4;
    localparam int POS_EXZ_CNT_EN    = 2;
    localparam int BIT_REPORT_MODE   = 1;
    localparam int BIT_XFER_TRIG     = 0;
    localparam int POS_TX_TERM       = 3;
    localparam int BIT_LOS_STATUS    = 0;

    // ====
    // Detection limits, in bit intervals
    localparam logic [11:0] LOS_RUN_SHORT    = 12'h020;
    localparam logic [11:0] LOS_RUN_LONG     = 12'h800;
    localparam logic [4:0]  CLR_WIN_LAST     = 5'h1F;
    localparam logic [5:0]  CLR_MIN_MARKS    = 6'h04;
    localparam logic [4:0]  CLR_ZERO_RUN     = 5'h10;
    localparam logic [6:0]  EXZ_LIM_AMI_STD  = 7'h0F;
    localparam logic [6:0]  EXZ_LIM_AMI_ALT  = 7'h50;
    localparam logic [6:0]  EXZ_LIM_HDB3     = 7'h03;
    localparam logic [1:0]  EXZ_COUNT_ON     = 2'h1;
    localparam logic [8:0]  PEAK_BASE_BITS   = 9'h020;

    // ====
    // Timing
    localparam longint REPORT_PERIOD_NS  = 64'd1_000_000_000;
    localparam longint CLK_PERIOD_NS     = 64'd100;
    localparam int unsigned REPORT_PERIOD_CYCLES =
        int'(REPORT_PERIOD_NS / CLK_PERIOD_NS);

    // ====
    // Carriers
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } e1lm_bus_s;

    typedef struct packed {
        logic [4:0] signal_loss_threshold;
        logic       equalizer_long_haul;
        logic [1:0] mark_detect_threshold;
        logic [1:0] peak_observe_period;
        logic [1:0] monitor_gain;
        logic [2:0] tx_term_sel;
        logic       tx_term_bypass;
    } e1lm_cfg_s;

    typedef struct packed {
        logic local_digital_loopback_one;
        logic system_local_loopback;
        logic system_remote_loopback;
        logic remote_loopback;
        logic analog_loopback;
        logic local_digital_loopback_two;
    } e1lm_loop_s;

    typedef struct packed {
        logic [7:0]  rx_code;
        logic [7:0]  rx_level;
        logic [7:0]  slicer;
        logic [7:0]  loopback;
        logic [7:0]  loss_ctrl;
        logic [7:0]  viol_exz;
        logic [7:0]  term;
        logic [3:0]  sync_a;
        logic [3:0]  sync_b;
        logic        strobe_d;
        logic        los;
        logic [11:0] below_run;
        logic [4:0]  win_cnt;
        logic [5:0]  win_marks;
        logic [4:0]  win_zero_run;
        logic        win_bad;
        logic [6:0]  exz_run;
        logic [15:0] exz_cnt;
        logic [15:0] exz_result;
        logic [31:0] sec_cnt;
        logic [8:0]  peak_cnt;
        logic        peak_end;
        logic        bpv_pulse;
        logic        rx_out;
        logic        tx_out;
        logic [7:0]  rdata;
    } e1lm_state_s;

endpackage : e1lm_pkg

// *** src/e1lm_ctrl.sv ***
/*
 * E1 line maintenance control: register bank, loss-of-signal declare and
 * clear, all-ones insertion, violation injection, excess-zero detection,
 * counting and reporting, peak window timing and analog configuration.
 * Assumes a single 10 MHz clock, a byte-wide register port with read data
 * one cycle after the strobe, and a receive front end that supplies a bit
 * strobe, the decoded data bit and two level comparator outputs, all
 * asynchronous to the device clock.
 */
// Design decision made here: the plain strobed port.
//
// Notes on behaviour
// - Long haul: five-bit field sets loss declare level, -4 dB to -48 dB.
// - Slicer reports a mark above 40/50/60/70 percent of peak.
// - Peak measured over 32, 64, 128 or 256 bit periods.
// - Monitor gain 0 dB or 22 dB; codes 10 and 11 reserved.
// - Six loopback bits each enable their own path when set.
// - Criterion 0: declare loss after 32 consecutive low intervals.
// - Criterion 1: declare loss after 2048 consecutive low intervals.
// - Clear loss on high level, 12.5 percent marks, no run of 16 zeros per 32.
// - Receive all-ones bit plus loss replaces receive data with ones.
// - Transmit all-ones bit plus loss sends ones on transmit.
// - Each rising inject bit inserts exactly one bipolar violation.
// - Criterion 0: excess zeros beyond 15 in AMI, beyond 3 in HDB3.
// - Criterion 1: excess zeros beyond 80 in AMI, beyond 3 in HDB3.
// - Counter increments on excess-zero events only with enable field 01.
// - Manual mode: rising transfer trigger copies counter to results.
// - Auto mode: counter copied to results once every second.
// - Transmit impedance 75/120/100/110 ohm; codes 1xx bypass internally.
// - Line code bit: 0 HDB3, 1 AMI; picks the excess-zero limit.
// - Equalizer bit: 1 long haul, 0 short haul; picks loss levels.
`timescale 1ns/10ps

module e1lm_ctrl #(
    parameter int unsigned REPORT_CYCLES = e1lm_pkg::REPORT_PERIOD_CYCLES
) (
    input  wire logic                 clk,
    input  wire logic                 srst,
    input  wire e1lm_pkg::e1lm_bus_s  bus,
    output logic [7:0]                rdata,
    input  wire logic                 rx_bit_strobe,
    input  wire logic                 rx_data_in,
    input  wire logic                 level_below_declare,
    input  wire logic                 level_above_clear,
    input  wire logic                 tx_data_in,
    output logic                      rx_data_out,
    output logic                      tx_data_out,
    output logic                      violation_insert,
    output logic                      peak_window_end,
    output logic                      loss_of_signal,
    output e1lm_pkg::e1lm_cfg_s       cfg,
    output e1lm_pkg::e1lm_loop_s      loops
);
    import e1lm_pkg::*;

    // ====
    // Helpers
    function automatic logic [7:0] masked_write(input logic [7:0] wdata,
                                                input logic [7:0] mask);
        masked_write = wdata & mask;
    endfunction : masked_write

    function automatic logic rose(input logic old_bit,
                                  input logic new_bit);
        rose = new_bit & ~old_bit;
    endfunction : rose

    // ====
    // State
    e1lm_state_s st;
    e1lm_state_s nx;

    logic        wr_hit_viol;
    logic        bit_tick;
    logic        data_bit;
    logic        below;
    logic        above;
    logic        long_haul;
    logic        ami;
    logic [11:0] declare_run;
    logic [6:0]  exz_limit;
    logic        exz_event;
    logic        transfer;
    logic        win_last;
    logic [8:0]  peak_len;

    always_comb begin
        nx = st;

        // ====
        // Register writes
        wr_hit_viol = bus.wr && (bus.addr == OFS_VIOL_EXZ);
        if (bus.wr) begin
            unique case (bus.addr)
                OFS_RX_CODE:   nx.rx_code   = masked_write(bus.wdata, MSK_RX_CODE);
                OFS_RX_LEVEL:  nx.rx_level  = masked_write(bus.wdata, MSK_RX_LEVEL);
                OFS_SLICER:    nx.slicer    = masked_write(bus.wdata, MSK_SLICER);
                OFS_LOOPBACK:  nx.loopback  = masked_write(bus.wdata, MSK_LOOPBACK);
                OFS_LOSS_CTRL: nx.loss_ctrl = masked_write(bus.wdata, MSK_LOSS_CTRL);
                OFS_VIOL_EXZ:  nx.viol_exz  = masked_write(bus.wdata, MSK_VIOL_EXZ);
                OFS_TERM:      nx.term      = masked_write(bus.wdata, MSK_TERM);
                default: ;
            endcase
        end

        // Inject pulse: one per rising write of the bit
        nx.bpv_pulse = wr_hit_viol
            && rose(st.viol_exz[BIT_VIOL_INJECT], bus.wdata[BIT_VIOL_INJECT]);

        // ====
        // Front end synchronisers; only stage b is ever read
        nx.sync_a   = {level_above_clear, level_below_declare, rx_data_in, rx_bit_strobe};
        nx.sync_b   = st.sync_a;
        nx.strobe_d = st.sync_b[0];
        bit_tick    = rose(st.strobe_d, st.sync_b[0]);
        data_bit    = st.sync_b[1];
        below       = st.sync_b[2];
        above       = st.sync_b[3];

        long_haul   = st.rx_level[BIT_LONG_HAUL];
        ami         = st.rx_code[BIT_RX_CODE_AMI];

        // ====
        // Loss of signal declare; level limit chosen in front end by haul
        declare_run = st.loss_ctrl[BIT_LOSS_CRIT] ? LOS_RUN_LONG : LOS_RUN_SHORT;
        win_last    = (st.win_cnt == CLR_WIN_LAST);
        if (bit_tick) begin
            if (below) begin
                if (st.below_run != declare_run) begin
                    nx.below_run = st.below_run + 12'h001;
                end
                if (!st.los && (st.below_run + 12'h001 == declare_run)) begin
                    nx.los = 1'b1;
                end
            end else begin
                nx.below_run = 12'h000;
            end

            // Clearing is judged per 32-bit window
            nx.win_cnt = st.win_cnt + 5'h01;
            if (win_last) begin
                if (st.los && !st.win_bad && above
                    && (st.win_marks + {5'h00, data_bit} >= CLR_MIN_MARKS)
                    && (data_bit || st.win_zero_run + 5'h01 < CLR_ZERO_RUN)) begin
                    nx.los = 1'b0;
                end
                nx.win_marks    = 6'h00;
                nx.win_zero_run = 5'h00;
                nx.win_bad      = 1'b0;
            end else begin
                nx.win_marks = st.win_marks + {5'h00, data_bit};
                if (data_bit) begin
                    nx.win_zero_run = 5'h00;
                end else begin
                    nx.win_zero_run = st.win_zero_run + 5'h01;
                end
                // A low level or a long zero run spoils the whole window
                if (!above || (!data_bit && st.win_zero_run + 5'h01 >= CLR_ZERO_RUN)) begin
                    nx.win_bad = 1'b1;
                end
            end
        end

        // ====
        // Excess zeros: one event per run, at the first zero past the limit
        if (ami) begin
            exz_limit = st.viol_exz[BIT_EXZ_CRIT] ? EXZ_LIM_AMI_ALT : EXZ_LIM_AMI_STD;
        end else begin
            exz_limit = EXZ_LIM_HDB3;
        end
        exz_event = bit_tick && !data_bit && (st.exz_run == exz_limit);
        if (bit_tick) begin
            if (data_bit) begin
                nx.exz_run = 7'h00;
            end else if (st.exz_run != 7'h7F) begin
                nx.exz_run = st.exz_run + 7'h01;
            end
        end

        // ====
        // Counter and reporting
        nx.sec_cnt = 32'h0000_0000;
        if (st.viol_exz[BIT_REPORT_MODE] && (st.sec_cnt != 32'(REPORT_CYCLES - 1))) begin
            nx.sec_cnt = st.sec_cnt + 32'h0000_0001;
        end
        if (st.viol_exz[BIT_REPORT_MODE]) begin
            transfer = (st.sec_cnt == 32'(REPORT_CYCLES - 1));
        end else begin
            // Trigger is ignored in auto mode
            transfer = wr_hit_viol && !bus.wdata[BIT_REPORT_MODE]
                && rose(st.viol_exz[BIT_XFER_TRIG], bus.wdata[BIT_XFER_TRIG]);
        end
        if (exz_event && st.viol_exz[POS_EXZ_CNT_EN +: 2] == EXZ_COUNT_ON) begin
            nx.exz_cnt = st.exz_cnt + 16'h0001;
        end
        if (transfer) begin
            nx.exz_result = st.exz_cnt;
            // Restart so each report covers one interval; a coincident event is kept
            nx.exz_cnt = (exz_event && st.viol_exz[POS_EXZ_CNT_EN +: 2] == EXZ_COUNT_ON)
                ? 16'h0001 : 16'h0000;
        end

        // ====
        // Peak observation window timing
        peak_len = PEAK_BASE_BITS << st.slicer[POS_PEAK_PER +: 2];
        nx.peak_end = 1'b0;
        if (bit_tick) begin
            if (st.peak_cnt + 9'h001 >= peak_len) begin
                nx.peak_cnt = 9'h000;
                nx.peak_end = 1'b1;
            end else begin
                nx.peak_cnt = st.peak_cnt + 9'h001;
            end
        end

        // ====
        // Data paths with all-ones substitution
        nx.rx_out = (st.loss_ctrl[BIT_RX_ALL_ONES] && st.los) ? 1'b1 : data_bit;
        nx.tx_out = (st.loss_ctrl[BIT_TX_ALL_ONES] && st.los) ? 1'b1 : tx_data_in;

        // ====
        // Register reads; unmapped addresses read zero
        nx.rdata = 8'h00;
        if (bus.rd) begin
            unique case (bus.addr)
                OFS_RX_CODE:     nx.rdata = st.rx_code;
                OFS_RX_LEVEL:    nx.rdata = st.rx_level;
                OFS_SLICER:      nx.rdata = st.slicer;
                OFS_LOOPBACK:    nx.rdata = st.loopback;
                OFS_LOSS_CTRL:   nx.rdata = st.loss_ctrl;
                OFS_VIOL_EXZ:    nx.rdata = st.viol_exz;
                OFS_TERM:        nx.rdata = st.term;
                OFS_LINE_STATUS: nx.rdata = {7'h00, st.los};
                OFS_EXZ_CNT_LO:  nx.rdata = st.exz_result[7:0];
                OFS_EXZ_CNT_HI:  nx.rdata = st.exz_result[15:8];
                default:         nx.rdata = 8'h00;
            endcase
        end

        if (srst) begin
            nx           = '0;
            nx.rx_code   = RST_RX_CODE;
            nx.rx_level  = RST_RX_LEVEL;
            nx.slicer    = RST_SLICER;
            nx.loopback  = RST_LOOPBACK;
            nx.loss_ctrl = RST_LOSS_CTRL;
            nx.viol_exz  = RST_VIOL_EXZ;
            nx.term      = RST_TERM;
        end
    end

    always_ff @(posedge clk) begin
        st <= nx;
    end

    // ====
    // Outputs, all straight from flops
    assign rdata            = st.rdata;
    assign rx_data_out      = st.rx_out;
    assign tx_data_out      = st.tx_out;
    assign violation_insert = st.bpv_pulse;
    assign peak_window_end  = st.peak_end;
    assign loss_of_signal   = st.los;

    // Threshold only meaningful to the front end in long haul
    assign cfg.signal_loss_threshold = st.rx_level[POS_LOSS_THR +: 5];
    assign cfg.equalizer_long_haul   = st.rx_level[BIT_LONG_HAUL];
    assign cfg.mark_detect_threshold = st.slicer[POS_MARK_THR +: 2];
    assign cfg.peak_observe_period   = st.slicer[POS_PEAK_PER +: 2];
    // Reserved gain codes pass through unchanged
    assign cfg.monitor_gain          = st.slicer[POS_MON_GAIN +: 2];
    assign cfg.tx_term_sel           = st.term[POS_TX_TERM +: 3];
    assign cfg.tx_term_bypass        = st.term[POS_TX_TERM + 2];

    assign loops.local_digital_loopback_one = st.loopback[BIT_LB_DIGITAL1];
    assign loops.system_local_loopback      = st.loopback[BIT_LB_SYS_LOCAL];
    assign loops.system_remote_loopback     = st.loopback[BIT_LB_SYS_REMOTE];
    assign loops.remote_loopback            = st.loopback[BIT_LB_REMOTE];
    assign loops.analog_loopback            = st.loopback[BIT_LB_ANALOG];
    assign loops.local_digital_loopback_two = st.loopback[BIT_LB_DIGITAL2];

endmodule : e1lm_ctrl

// *** tb/e1lm_line_model.sv ***
/* Line-side model: bit strobe and decoded receive data of the E1 line.
   Assumes the bench clock; the line starts when run rises. */
`timescale 1ns/10ps

module e1lm_line_model (
    input  wire logic       clk,
    input  wire logic       run,
    input  wire logic [7:0] zrun,
    output logic            strobe,
    output logic            data
);
    // ====
    // Bit timing: 8 clk a bit, so each strobe phase lasts 4 clk
    logic [2:0] ph  = 3'h0;
    logic [7:0] cnt = 8'h00;
    initial strobe = 1'b0;
    initial data = 1'b1;
    always @(posedge clk) begin
        if (run) begin
            ph     <= ph + 3'h1;
            strobe <= ph[2];
            // Data moves mid-bit, well clear of the strobe edge
            if (ph == 3'h0) begin
                cnt  <= (cnt >= zrun) ? 8'h00 : cnt + 8'h01;
                data <= (cnt >= zrun);
            end
        end else begin
            // Idle line toggles so a stale bit is never taken for data
            data <= ~data;
        end
    end
endmodule : e1lm_line_model

// *** tb/e1lm_ctrl_sva.sv ***
/* Port assertions for the line maintenance block.
   Assumes one clock and the synchronous active-high reset. */
`timescale 1ns/10ps

module e1lm_ctrl_sva (
    input wire logic                 clk,
    input wire logic                 srst,
    input wire e1lm_pkg::e1lm_bus_s  bus,
    input wire logic                 tx_data_in,
    input wire logic                 rx_data_out,
    input wire logic                 tx_data_out,
    input wire logic                 violation_insert,
    input wire logic                 peak_window_end,
    input wire logic                 loss_of_signal,
    input wire e1lm_pkg::e1lm_cfg_s  cfg,
    input wire e1lm_pkg::e1lm_loop_s loops
);
    import e1lm_pkg::*;
    // ====
    // Shadows of the bits whose effect depends on history
    logic       inj_q;
    logic [1:0] ao_q;
    wire        inj_rise = bus.wr && bus.addr == OFS_VIOL_EXZ && bus.wdata[6] && !inj_q;
    always_ff @(posedge clk) begin
        if (srst) begin
            inj_q <= 1'b0;
            ao_q  <= 2'h0;
        end else if (bus.wr && bus.addr == OFS_VIOL_EXZ) begin
            inj_q <= bus.wdata[BIT_VIOL_INJECT];
        end else if (bus.wr && bus.addr == OFS_LOSS_CTRL) begin
            ao_q <= bus.wdata[3:2];
        end
    end
    // ====
    // Properties
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    sequence s_wr(ofs);
        bus.wr && bus.addr == ofs;
    endsequence
    sequence s_loss_ones(b);
        (loss_of_signal && b) [*2];
    endsequence
    chk_inject_rise: assert property (inj_rise |=> violation_insert)
        else $error("no violation pulse after inject set");
    chk_inject_cause: assert property (violation_insert |-> $past(inj_rise))
        else $error("violation pulse without inject rise");
    chk_tx_ones: assert property (s_loss_ones(ao_q[0]) |-> tx_data_out)
        else $error("transmit not all ones in loss");
    chk_tx_pass: assert property ((!loss_of_signal) [*2] |-> tx_data_out == $past(tx_data_in))
        else $error("transmit data altered without loss");
    chk_rx_ones: assert property (s_loss_ones(ao_q[1]) |-> rx_data_out)
        else $error("receive not all ones in loss");
    chk_loop_map: assert property (s_wr(OFS_LOOPBACK) |=>
        loops == {$past(bus.wdata[6:4]), $past(bus.wdata[2:0])})
        else $error("loopback enables differ from write");
    chk_slicer_map: assert property (s_wr(OFS_SLICER) |=>
        {cfg.mark_detect_threshold, cfg.peak_observe_period, cfg.monitor_gain}
        == $past(bus.wdata[5:0]))
        else $error("slicer fields differ from write");
    chk_term_map: assert property (s_wr(OFS_TERM) |=>
        {cfg.tx_term_bypass, cfg.tx_term_sel} == {$past(bus.wdata[5]), $past(bus.wdata[5:3])})
        else $error("termination fields differ from write");
    chk_peak_pulse: assert property (peak_window_end |=> (!peak_window_end) [*8])
        else $error("peak window pulses too close");
endmodule : e1lm_ctrl_sva

bind e1lm_ctrl e1lm_ctrl_sva i_sva (.*);

// *** tb/e1lm_ctrl_tb.sv ***
/* Bench for the line maintenance block: register port tasks, a line model
   and table-driven checks. Assumes the checker is bound into the block. */
`timescale 1ns/10ps

module e1lm_ctrl_tb;
    import e1lm_pkg::*;
    // ====
    // Signals; one report of 400 clk spans exactly ten 40-clk patterns
    localparam int unsigned RPT = 400;
    logic        clk, rxo, txo, viol, pk, los, stb, rxd;
    logic        srst = 1'b1, txd = 1'b0, below = 1'b0, above = 1'b1, run = 1'b0;
    logic [7:0]  zrun = 8'h00, rdata, rd, lo, d;
    e1lm_bus_s   bus = '0;
    e1lm_cfg_s   cfg;
    e1lm_loop_s  loops;
    int          num_errors = 0, comparisons = 0, nviol = 0, nt = 0, pk_at = 0, gap = 0, lim;
    logic [7:0]  ofs [7] = '{OFS_RX_CODE, OFS_RX_LEVEL, OFS_SLICER, OFS_LOOPBACK,
                             OFS_LOSS_CTRL, OFS_VIOL_EXZ, OFS_TERM};
    logic [7:0]  rst [7] = '{RST_RX_CODE, RST_RX_LEVEL, RST_SLICER, RST_LOOPBACK,
                             RST_LOSS_CTRL, RST_VIOL_EXZ, RST_TERM};
    logic [7:0]  msk [7] = '{MSK_RX_CODE, MSK_RX_LEVEL, MSK_SLICER, MSK_LOOPBACK,
                             MSK_LOSS_CTRL, MSK_VIOL_EXZ, MSK_TERM};
    // Cases: {AMI, alternate limit, count enable[1:0], zeros before each one}
    logic [11:0] exz [8] = '{12'h103, 12'h104, 12'h90F, 12'h910, 12'hD50, 12'hD51,
                             12'h504, 12'h204};
    e1lm_ctrl #(.REPORT_CYCLES(RPT)) i_dut (.clk(clk), .srst(srst), .bus(bus), .rdata(rdata),
        .rx_bit_strobe(stb), .rx_data_in(rxd), .level_below_declare(below),
        .level_above_clear(above), .tx_data_in(txd), .rx_data_out(rxo), .tx_data_out(txo),
        .violation_insert(viol), .peak_window_end(pk), .loss_of_signal(los), .cfg(cfg),
        .loops(loops));
    e1lm_line_model i_line (.clk(clk), .run(run), .zrun(zrun), .strobe(stb), .data(rxd));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge stb) nt++;
    always @(posedge viol) nviol++;
    always @(posedge clk) begin
        if (pk === 1'b1) begin
            gap   = nt - pk_at;
            pk_at = nt;
        end
    end
    // ====
    // Tasks
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // One strobe cycle, then idle; read data are taken in the cycle after
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        bus <= '{addr: a, wdata: v, wr: w, rd: !w};
        @(posedge clk);
        bus <= '{addr: a, wdata: v, wr: 1'b0, rd: 1'b0};
        @(negedge clk);
        rd = rdata;
    endtask : acc
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        acc(1'b0, a, 8'h00);
        chk($sformatf("reg %h", a), rd, exp);
    endtask : rc
    // Ends mid-bit, so the line inputs change away from a strobe edge
    task automatic ticks(input int n);
        repeat (n) @(posedge stb);
        repeat (6) @(posedge clk);
        @(negedge clk);
    endtask : ticks
    task automatic lvl(input logic b, input logic a, input logic [7:0] z);
        ticks(1);
        @(posedge clk);
        below <= b;
        above <= a;
        zrun  <= z;
    endtask : lvl
    task automatic count(input logic [15:0] exp);
        acc(1'b0, OFS_EXZ_CNT_LO, 8'h00);
        lo = rd;
        acc(1'b0, OFS_EXZ_CNT_HI, 8'h00);
        chk("exz count", {rd, lo}, exp);
    endtask : count
    task automatic summarize();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize
    // ====
    // Tests
    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        run  <= 1'b1;
        chk("cfg", cfg, {5'h15, 1'b0, 2'h1, 2'h2, 2'h0, 3'h0, 1'b0});
        foreach (ofs[i]) begin
            rc(ofs[i], rst[i]);
            acc(1'b1, ofs[i], 8'hFF);
            rc(ofs[i], msk[i]);
            acc(1'b1, ofs[i], 8'h00);
        end
        rc(8'h30, 8'h00);
        for (int b = 0; b < 8; b++) begin
            acc(1'b1, OFS_LOOPBACK, 8'h01 << b);
            chk("loops", loops, (b == 3 || b == 7) ? 6'h00 : 6'h01 << (b > 3 ? b - 1 : b));
        end
        for (int i = 0; i < 8; i++) begin
            acc(1'b1, OFS_TERM, 8'(i << 3));
            chk("term", {cfg.tx_term_bypass, cfg.tx_term_sel}, {i[2], i[2:0]});
            d = 8'((i << 4) | (i << 2) | (i & 1));
            acc(1'b1, OFS_SLICER, d);
            chk("slicer", cfg[9:4], d & 8'h3F);
        end
        acc(1'b1, OFS_RX_LEVEL, 8'h5F);
        chk("level", {cfg.equalizer_long_haul, cfg.signal_loss_threshold}, 6'h3F);
        acc(1'b1, OFS_RX_LEVEL, 8'h00);
        $display("test registers finished");
        nviol = 0;
        acc(1'b1, OFS_VIOL_EXZ, 8'h40);
        acc(1'b1, OFS_VIOL_EXZ, 8'h40);
        acc(1'b1, OFS_VIOL_EXZ, 8'h00);
        acc(1'b1, OFS_VIOL_EXZ, 8'h40);
        chk("violations", nviol, 16'h0002);
        $display("test inject finished");
        for (int c = 0; c < 4; c++) begin
            acc(1'b1, OFS_SLICER, 8'(c << 2));
            ticks((32 << c) * 2 + 8);
            chk("peak gap", gap, 32 << c);
        end
        $display("test peak finished");
        acc(1'b1, OFS_LOSS_CTRL, 8'h0C);
        lvl(1'b1, 1'b0, 8'hFF);
        ticks(31);
        chk("loss", los, 1'b0);
        ticks(1);
        chk("loss", los, 1'b1);
        chk("tx ones", txo, 1'b1);
        chk("rx ones", rxo, 1'b1);
        rc(OFS_LINE_STATUS, 8'h01);
        acc(1'b1, OFS_LOSS_CTRL, 8'h00);
        @(negedge clk);
        chk("tx pass", txo, 1'b0);
        lvl(1'b0, 1'b1, 8'hFF);
        ticks(70);
        chk("loss", los, 1'b1);
        lvl(1'b0, 1'b0, 8'h00);
        ticks(70);
        chk("loss", los, 1'b1);
        lvl(1'b0, 1'b1, 8'h00);
        ticks(70);
        chk("loss", los, 1'b0);
        acc(1'b1, OFS_LOSS_CTRL, 8'h10);
        lvl(1'b1, 1'b0, 8'h00);
        ticks(2047);
        chk("loss", los, 1'b0);
        ticks(1);
        chk("loss", los, 1'b1);
        lvl(1'b0, 1'b1, 8'h00);
        ticks(70);
        chk("loss", los, 1'b0);
        $display("test loss finished");
        foreach (exz[i]) begin
            lim = exz[i][11] ? (exz[i][10] ? 80 : 15) : 3;
            acc(1'b1, OFS_RX_CODE, {7'h00, exz[i][11]});
            acc(1'b1, OFS_VIOL_EXZ, {3'h0, exz[i][10:8], 2'h0});
            lvl(1'b0, 1'b1, exz[i][7:0]);
            ticks(2 * exz[i][7:0] + 2);
            acc(1'b1, OFS_VIOL_EXZ, {3'h0, exz[i][10:8], 2'h1});
            ticks(4 * exz[i][7:0] + 3);
            acc(1'b1, OFS_VIOL_EXZ, {3'h0, exz[i][10:8], 2'h0});
            acc(1'b1, OFS_VIOL_EXZ, {3'h0, exz[i][10:8], 2'h1});
            count((exz[i][9:8] == 2'h1 && exz[i][7:0] > lim) ? 16'h0004 : 16'h0000);
        end
        acc(1'b1, OFS_RX_CODE, 8'h00);
        lvl(1'b0, 1'b1, 8'h04);
        acc(1'b1, OFS_VIOL_EXZ, 8'h06);
        repeat (1000) @(posedge clk);
        count(16'h000A);
        $display("test excess zeros finished");
        summarize();
    end
    initial begin
        repeat (80000) @(posedge clk);
        num_errors++;
        $display("watchdog expired");
        summarize();
    end
endmodule : e1lm_ctrl_tb
